// ---- deser_top.sv ----
// How it works
// - Serial bits gathered into sixteen-bit words
// - Realignment finished within two word clocks
// - Realignment drops first bit of word cycle
// - Lock flag drops low at once on loss
// - Lock flag rises about 800 ns after lock
// - Missing input signal is not flagged
// - Select high takes the loopback input
// - Detector samples I/Q on data edges, steers
// - Detector goes neutral once locked
// - Data changes on word clock falling edge
// - Select low takes the main input
`timescale 1ns/10ps
`default_nettype none
module deser_top import deser_pkg::*; #(
  parameter int LOCK_RELEASE = LOCK_RELEASE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial link, asynchronous to hclk
  input wire logic link_clk,
  input wire logic main_serial_input,
  input wire logic loopback_serial_input,
  input wire logic realign_pulse,
  // Parallel side
  output logic [WORD_W-1:0] parallel_data_out,
  output logic word_clk,
  output logic lock_lost_flag_n,
  // Interrupt
  output logic irq
);
  logic [3:0] raw_in;
  logic [3:0] sync_lvl;
  logic [3:0] sync_rise;
  logic s_link;
  logic s_main;
  logic s_loop;
  logic s_realign;
  logic link_rise;
  logic realign_rise;

  assign raw_in = {realign_pulse, loopback_serial_input, main_serial_input, link_clk};

  edge_sync #(.W(4)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(raw_in),
    .q(sync_lvl),
    .rise(sync_rise),
    .fall()
  );

  assign s_link = sync_lvl[0];
  assign s_main = sync_lvl[1];
  assign s_loop = sync_lvl[2];
  assign s_realign = sync_lvl[3];
  assign link_rise = sync_rise[0];
  // Pulses shorter than one hclk period may be missed; the far side keeps them wide
  assign realign_rise = sync_rise[3];

  // Registers
  logic [31:0] ctrl_q;
  logic [IRQ_N-1:0] irq_stat_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic src_sel;
  assign src_sel = ctrl_q[CTRL_SRC_SEL];

  // Input selection
  logic sel_data;
  logic sel_prev_q;
  logic data_edge;
  assign sel_data = src_sel ? s_loop : s_main;
  assign data_edge = sel_data ^ sel_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_data;
    end
  end

  // Frequency detector; no data means no edges, so no loss is reported
  logic fd_locked;
  freq_detector u_fd (
    .clk(hclk),
    .rst_n(hresetn),
    .data_edge(data_edge),
    .freq_locked(fd_locked)
  );

  // Deserializer
  logic [WORD_W-1:0] shift_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic realign_pend_q;
  logic [WORD_W-1:0] parallel_data_out_q;
  logic word_clk_q;
  logic bit_take;
  logic drop_now;
  logic keep_bit;
  logic word_done;
  logic [WORD_W-1:0] next_word;

  assign bit_take = link_rise;
  assign drop_now = bit_take && realign_pend_q && bit_cnt_q == FIRST_BIT;
  assign keep_bit = bit_take && !drop_now;
  assign word_done = keep_bit && bit_cnt_q == LAST_BIT;
  assign next_word = {shift_q[WORD_W-2:0], sel_data};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= '0;
      bit_cnt_q <= FIRST_BIT;
    end else if (keep_bit) begin
      shift_q <= next_word;
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // A fresh edge wins over the drop that clears the previous one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      realign_pend_q <= 1'b0;
    end else begin
      realign_pend_q <= realign_rise || (realign_pend_q && !drop_now);
    end
  end

  // Word clock low half starts with new data, so the far side samples on its rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      parallel_data_out_q <= '0;
      word_clk_q <= 1'b1;
    end else if (word_done) begin
      parallel_data_out_q <= next_word;
      word_clk_q <= 1'b0;
    end else if (keep_bit && bit_cnt_q == MID_BIT) begin
      word_clk_q <= 1'b1;
    end
  end

  // Lock flag
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic lock_flag_q;
  logic seen_lock_q;
  logic lock_release;
  assign lock_release = fd_locked && lock_cnt_q == LOCK_CNT_W'(LOCK_RELEASE - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_q <= '0;
      lock_flag_q <= 1'b0;
    end else if (!fd_locked) begin
      lock_cnt_q <= '0;
      lock_flag_q <= 1'b0;
    end else if (lock_release) begin
      lock_flag_q <= 1'b1;
    end else if (!lock_flag_q) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  logic fd_locked_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fd_locked_prev_q <= 1'b0;
      seen_lock_q <= 1'b0;
    end else begin
      fd_locked_prev_q <= fd_locked;
      seen_lock_q <= seen_lock_q || fd_locked;
    end
  end

  // Interrupt events
  logic [IRQ_N-1:0] events;
  assign events[IRQ_WORD] = word_done;
  assign events[IRQ_LOST] = fd_locked_prev_q && !fd_locked;
  assign events[IRQ_GAINED] = lock_release && !lock_flag_q;
  assign events[IRQ_REALIGN] = drop_now;

  // AHB-Lite slave, zero wait states
  logic a_valid;
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic [7:0] a_addr;
  logic wr_ctrl;
  logic wr_en;
  logic wr_clr;
  logic [IRQ_N-1:0] clr_mask;

  assign a_valid = hsel && hready && htrans[1];
  assign a_addr = haddr[7:0];
  assign wr_ctrl = wr_pend_q && waddr_q == REG_CTRL;
  assign wr_en = wr_pend_q && waddr_q == REG_IRQ_EN;
  assign wr_clr = wr_pend_q && waddr_q == REG_IRQ_CLR;
  assign clr_mask = wr_clr ? hwdata[IRQ_N-1:0] : '0;
  assign rd_val = (a_addr == REG_CTRL) ? ctrl_q :
                  (a_addr == REG_STATUS) ? {29'h0000_0000, realign_pend_q, lock_flag_q, fd_locked} :
                  (a_addr == REG_DATA) ? {16'h0000, parallel_data_out_q} :
                  (a_addr == REG_IRQ_STAT) ? {28'h000_0000, irq_stat_q} :
                  (a_addr == REG_IRQ_EN) ? {28'h000_0000, irq_en_q} :
                  32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_pend_q <= a_valid && hwrite;
      if (a_valid) begin
        waddr_q <= a_addr;
      end
      if (a_valid && !hwrite) begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
      irq_en_q <= IRQ_EN_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata & (32'h0000_0001 << CTRL_SRC_SEL);
      end
      if (wr_en) begin
        irq_en_q <= hwdata[IRQ_N-1:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  logic irq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= events | (irq_stat_q & ~clr_mask);
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // Output flops
  logic hreadyout_q;
  logic hresp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign parallel_data_out = parallel_data_out_q;
  assign word_clk = word_clk_q;
  assign lock_lost_flag_n = lock_flag_q;
  assign irq = irq_q;

  // Helper counters for checks
  logic [BIT_CNT_W:0] bits_since_q;
  logic [1:0] words_pend_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bits_since_q <= '0;
      words_pend_q <= '0;
    end else begin
      if (word_done) begin
        bits_since_q <= '0;
      end else if (keep_bit && bits_since_q != 5'h1F) begin
        bits_since_q <= bits_since_q + 1'b1;
      end
      if (!realign_pend_q || realign_rise) begin
        words_pend_q <= '0;
      end else if (word_done && words_pend_q != 2'h3) begin
        words_pend_q <= words_pend_q + 1'b1;
      end
    end
  end

  default clocking top_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_locked_run;
    fd_locked [*3];
  endsequence

  chk_word_sixteen_bits: assert property (word_done && $past(word_done, 1) == 1'b0 |-> bits_since_q == 5'h0F)
    else $error("word assembled from wrong bit count");
  chk_realign_two_words: assert property (realign_pend_q |-> words_pend_q < 2'h2)
    else $error("realignment not done within two word clocks");
  chk_drop_one_bit: assert property (drop_now |=> $stable(shift_q) && bit_cnt_q == FIRST_BIT)
    else $error("dropped bit entered the word");
  chk_lock_loss_fast: assert property ($fell(fd_locked) |=> !lock_lost_flag_n)
    else $error("lock flag late on loss");
  chk_lock_release_time: assert property ($rose(lock_flag_q) |-> $past(lock_cnt_q) == LOCK_CNT_W'(LOCK_RELEASE - 1))
    else $error("lock flag released at wrong time");
  chk_lock_needs_run: assert property (!fd_locked ##1 s_locked_run |-> !lock_flag_q)
    else $error("lock flag released too early");
  chk_source_select: assert property (keep_bit |=> shift_q[0] == ($past(src_sel) ? $past(s_loop) : $past(s_main)))
    else $error("wrong serial source taken");
  chk_data_on_fall: assert property (!$stable(parallel_data_out_q) |-> $fell(word_clk_q))
    else $error("data changed off the falling word clock");
  chk_msb_first: assert property (word_done |=> parallel_data_out_q[WORD_W-1] == $past(shift_q[WORD_W-2]))
    else $error("bit order wrong");
  chk_flag_low_start: assert property (!seen_lock_q |-> !lock_lost_flag_n)
    else $error("lock flag high before first lock");
endmodule
`default_nettype wire

// ---- deser_pkg.sv ----
package deser_pkg;
  // Word geometry
  localparam int WORD_W = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [BIT_CNT_W-1:0] MID_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 4'h0;

  // Timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int LOCK_RELEASE_NS = 800;
  localparam int LOCK_RELEASE_CYC = (LOCK_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CNT_W = 8;
  // Least realign pulse width the far side must give, per serial bit
  localparam int REALIGN_MIN_BITS = 4;
  localparam int SERIAL_BIT_PS = 402;

  // Frequency detector oscillator
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_NOM_STEP = 16'h2000;
  localparam logic [NCO_W-1:0] NCO_TRIM = 16'h0010;
  localparam int FD_LOCK_SAMPLES = 16;
  localparam int FD_CNT_W = 6;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;

  // Field positions
  localparam int CTRL_SRC_SEL = 0;
  localparam int STAT_FREQ_LOCK = 0;
  localparam int STAT_LOCK_FLAG = 1;
  localparam int STAT_REALIGN_PEND = 2;
  localparam int IRQ_N = 4;
  localparam int IRQ_WORD = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_GAINED = 2;
  localparam int IRQ_REALIGN = 3;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [IRQ_N-1:0] IRQ_EN_RESET = 4'h0;
endpackage

// ---- edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module edge_sync import deser_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronous levels and edges out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ---- freq_detector.sv ----
`timescale 1ns/10ps
`default_nettype none
module freq_detector import deser_pkg::*; #(
  parameter int LOCK_SAMPLES = FD_LOCK_SAMPLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pulse on every transition of the selected data
  input wire logic data_edge,
  // Level, high while frequency-locked
  output logic freq_locked
);
  logic [NCO_W-1:0] phase_q;
  logic [NCO_W-1:0] step_q;
  logic [1:0] prev_quad_q;
  logic [FD_CNT_W-1:0] calm_q;
  logic locked_q;
  logic osc_i;
  logic osc_q;
  logic [1:0] quad;
  logic [1:0] delta;
  logic ahead;
  logic behind;
  logic still;

  // In-phase and quadrature taps of the oscillator
  assign osc_i = phase_q[NCO_W-1];
  assign osc_q = phase_q[NCO_W-1] ^ phase_q[NCO_W-2];
  assign quad = {osc_i, osc_i ^ osc_q};
  assign delta = quad - prev_quad_q;
  assign ahead = data_edge && delta == 2'h1;
  assign behind = data_edge && delta == 2'h3;
  assign still = data_edge && delta == 2'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      prev_quad_q <= '0;
    end else begin
      phase_q <= phase_q + step_q;
      if (data_edge) begin
        prev_quad_q <= quad;
      end
    end
  end

  // Steering stops once locked, so tracking noise cannot pull the loop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= NCO_NOM_STEP;
    end else if (!locked_q && ahead) begin
      step_q <= step_q - NCO_TRIM;
    end else if (!locked_q && behind) begin
      step_q <= step_q + NCO_TRIM;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calm_q <= '0;
      locked_q <= 1'b0;
    end else if (data_edge && !still) begin
      calm_q <= '0;
      locked_q <= 1'b0;
    end else if (still && !locked_q) begin
      calm_q <= calm_q + 1'b1;
      locked_q <= calm_q == FD_CNT_W'(LOCK_SAMPLES - 1);
    end
  end

  assign freq_locked = locked_q;

  default clocking fd_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_fd_neutral_hold: assert property (locked_q |=> $stable(step_q))
    else $error("oscillator steered while locked");
  chk_fd_steer_down: assert property (!locked_q && ahead |=> step_q == $past(step_q) - NCO_TRIM)
    else $error("oscillator not slowed when ahead");
endmodule
`default_nettype wire

// ---- deser_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module deser_far_end import deser_pkg::*; (
  // Link timing
  input wire logic link_clk,
  // Parallel side
  input wire logic word_clk,
  input wire logic [WORD_W-1:0] parallel_data_out,
  // Realign control and captured word
  input wire logic align_req,
  output var logic realign_pulse = 1'b0,
  output logic [WORD_W-1:0] rx_word
);
  int hold_cnt = 0;

  // Taken half a word after the data moved
  always @(posedge word_clk) begin
    rx_word <= parallel_data_out;
  end

  // One bit beyond the least width, so a late sample still sees it
  always @(posedge link_clk) begin
    if (align_req && hold_cnt == 0) begin
      realign_pulse <= 1'b1;
      hold_cnt <= REALIGN_MIN_BITS + 1;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
      if (hold_cnt == 1) realign_pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb import deser_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, link_clk, main_serial_input, loopback_serial_input, align_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, realign_pulse, word_clk, lock_lost_flag_n, irq;
  logic [WORD_W-1:0] parallel_data_out, rx_word;
  wire logic hready;
  int n_mismatch = 0;
  int cmp_count = 0;
  int pos = 0;
  logic req_m = 1'b0;
  logic sel_m = 1'b0;
  logic lost_seen = 1'b0;
  logic have_prev = 1'b0;
  logic [31:0] seed = 32'h0000_E9F4;
  logic [15:0] prev_exp;
  logic exp_q[$];

  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  deser_top #(.LOCK_RELEASE(4)) deser_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .main_serial_input(main_serial_input),
    .loopback_serial_input(loopback_serial_input), .realign_pulse(realign_pulse),
    .parallel_data_out(parallel_data_out), .word_clk(word_clk), .lock_lost_flag_n(lock_lost_flag_n), .irq(irq));

  deser_far_end deser_far_end_inst (.link_clk(link_clk), .word_clk(word_clk), .parallel_data_out(parallel_data_out),
    .align_req(align_req), .realign_pulse(realign_pulse), .rx_word(rx_word));

  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t bus stalled", $time);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    cmp_bit(hresp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    cmp_reg(q & m, exp);
  endtask

  // Data moves while the link clock is low, so it is settled at the rise
  task automatic send_bit(input int per);
    seed = xs(seed);
    main_serial_input = seed[0];
    loopback_serial_input = seed[1];
    if (req_m && pos == 0) begin
      req_m = 1'b0;
    end else begin
      exp_q.push_back(sel_m ? seed[1] : seed[0]);
      pos = (pos + 1) % 16;
    end
    #(per / 2) link_clk = 1'b1;
    #(per - per / 2) link_clk = 1'b0;
  endtask

  // Link edges kept off the hclk edges to avoid sampling races
  task automatic burst(input int words, input int per, input int ra_bit);
    #2;
    for (int i = 0; i < words * 16; i++) begin
      if (i == ra_bit) begin
        align_req = 1'b1;
        req_m = 1'b1;
      end
      send_bit(per);
      align_req = 1'b0;
    end
  endtask

  always @(negedge word_clk) begin
    #1;
    if (hresetn === 1'b1) begin
      if (have_prev) cmp_reg({16'h0000, rx_word}, {16'h0000, prev_exp});
      for (int k = 0; k < 16; k++) begin
        prev_exp = {prev_exp[14:0], (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx};
      end
      have_prev = 1'b1;
      cmp_reg({16'h0000, parallel_data_out}, {16'h0000, prev_exp});
    end
  end

  always @(negedge lock_lost_flag_n) begin
    if (hresetn === 1'b1) lost_seen = 1'b1;
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    link_clk = 1'b0;
    main_serial_input = 1'b0;
    loopback_serial_input = 1'b1;
    align_req = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp_bit(lock_lost_flag_n, 1'b0);
    cmp_reg({16'h0000, parallel_data_out}, 32'h0000_0000);
    rd_chk(REG_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    rd_chk(REG_IRQ_EN, 32'h0000_000F, {28'h0000000, IRQ_EN_RESET});
    rd_chk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rd_chk(REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    burst(6, 80, -1);
    repeat (10) @(posedge hclk);
    cmp_bit(lock_lost_flag_n, 1'b1);
    rd_chk(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    rd_chk(REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    // Long silence on the link must not read as a loss
    #3000;
    @(posedge hclk);
    cmp_bit(lock_lost_flag_n, 1'b1);
    wr(REG_CTRL, 32'h0000_0001);
    sel_m = 1'b1;
    burst(4, 80, -1);
    rd_chk(REG_CTRL, 32'h0000_0001, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0000);
    sel_m = 1'b0;
    burst(4, 80, 20);
    rd_chk(REG_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(REG_IRQ_EN, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    cmp_bit(irq, 1'b1);
    wr(REG_IRQ_CLR, 32'h0000_000F);
    repeat (3) @(posedge hclk);
    cmp_bit(irq, 1'b0);
    rd_chk(REG_IRQ_STAT, 32'h0000_000F, 32'h0000_0000);
    wr(REG_IRQ_EN, 32'h0000_0000);
    burst(2, 80, -1);
    repeat (3) @(posedge hclk);
    rd_chk(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    cmp_bit(irq, 1'b0);
    // Off-rate stream forces the detector out of lock
    burst(3, 50, -1);
    repeat (10) @(posedge hclk);
    cmp_bit(lost_seen, 1'b1);
    rd_chk(REG_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    end_of_test();
  end
endmodule
`default_nettype wire
